// ### dv/add_and_branch_bitclear_exec_props.sv
`timescale 1ns/1ps
module exec_checker
	import exec_pkg::*;
(
	input wire logic              ref_clk_in,
	input wire logic              reset_in,
	input wire logic              insn_valid_in,
	input wire logic [INSN_W-1:0] insn_in,
	input wire logic [FLAG_W-1:0] status_in,
	input wire result_t           result_out,
	input wire logic              flags_wr_out,
	input wire branch_t           branch_out,
	input wire logic              busy_out,
	input wire logic              done_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	sequence take_s;
		insn_valid_in && !busy_out;
	endsequence
	sequence take_bc_s;
		take_s ##0 insn_in[15:8] == OP_BRANCH_C;
	endsequence
	take_busy_a: assert property (take_s |=> busy_out)
		else $error("busy not raised after take");
	done_once_a: assert property (done_out |=> !done_out)
		else $error("done longer than one cycle");
	write_done_a: assert property ((result_out.wr_accum || result_out.wr_file) |-> done_out)
		else $error("write outside completion");
	one_cycle_a: assert property (take_s ##0 !(insn_in[15:8] == OP_BRANCH_C && status_in[FLAG_C])
		|-> ##5 done_out)
		else $error("instruction not done in one cycle");
	branch_flags_a: assert property (take_bc_s |=> !flags_wr_out[*8])
		else $error("branch changed flags");
	no_branch_a: assert property (take_bc_s ##0 !status_in[FLAG_C] |=> !branch_out.taken[*5])
		else $error("branch taken without carry");
	taken_extra_a: assert property (branch_out.taken |-> ##4 done_out)
		else $error("taken branch cycle count wrong");
	clear_flags_a: assert property (take_s ##0 insn_in[15:12] == OP_CLEAR_BIT
		|=> !flags_wr_out[*5])
		else $error("bit clear changed flags");
endmodule

bind add_and_branch_bitclear_exec exec_checker i_props (.ref_clk_in, .reset_in, .insn_valid_in,
	.insn_in, .status_in, .result_out, .flags_wr_out, .branch_out, .busy_out, .done_out);

// ### dv/add_and_branch_bitclear_exec_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module add_and_branch_bitclear_exec_tb_top;
	import exec_pkg::*;
	logic               ref_clk_in = 0, reset_in = 1, insn_valid_in = 0, extended_in = 0;
	logic [INSN_W-1:0]  insn_in = '0;
	logic [DATA_W-1:0]  accum_in = '0, file_data_in = '0;
	logic [FLAG_W-1:0]  status_in = '0, status_out;
	logic [ADDR_W-1:0]  read_addr_out;
	result_t            result_out;
	branch_t            branch_out;
	logic               flags_wr_out, busy_out, done_out, bt;
	logic [PHASE_W-1:0] phase_out;
	logic [PC_W-1:0]    tg;
	int                 miscompares = 0, n_tests = 0, cyc;

	add_and_branch_bitclear_exec i_dut (.ref_clk_in, .reset_in, .insn_valid_in, .insn_in,
		.accum_in, .file_data_in, .status_in, .program_counter_in(21'h000100),
		.bank_pointer_register_in(4'h3), .index_base_in(12'h100), .extended_in,
		.read_addr_out, .result_out, .flags_wr_out, .status_out, .branch_out,
		.phase_out, .busy_out, .done_out);

	initial begin
		forever #4 ref_clk_in = ~ref_clk_in;
	end

	task automatic summarize;
		$display("tests %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Issues one instruction and waits at falling edges for its completion.
	task automatic exec(input logic [15:0] i, input logic [7:0] w, fd,
		input logic [FLAG_W-1:0] st, input logic ex);
		insn_in = i;
		accum_in = w;
		file_data_in = fd;
		status_in = st;
		extended_in = ex;
		insn_valid_in = 1;
		bt = 0;
		@(negedge ref_clk_in);
		insn_valid_in = 0;
		`CHK({busy_out, phase_out}, 3'h4)
		for (cyc = 1; cyc < 20 && done_out !== 1'b1; cyc++) begin
			if (cyc == 3) `CHK(phase_out, 2'h2)
			if (branch_out.taken === 1'b1) begin
				bt = 1;
				tg = branch_out.target;
			end
			@(negedge ref_clk_in);
		end
		`CHK({busy_out, phase_out}, 3'h0)
	endtask

	initial begin
		repeat (500) @(posedge ref_clk_in);
		miscompares++;
		summarize();
	end

	initial begin
		repeat (6) @(negedge ref_clk_in);
		reset_in = 0;
		exec(16'h2102, 8'h4D, 8'h02, 5'h01, 1'b0);
		`CHK(result_out, {1'b1, 1'b0, 12'h302, 8'h50})
		`CHK({flags_wr_out, status_out}, 6'h22)
		`CHK(cyc, 5)
		exec(16'h2260, 8'h7F, 8'h00, 5'h01, 1'b1);
		`CHK(result_out, {1'b0, 1'b1, 12'hF60, 8'h80})
		`CHK(status_out, 5'h1A)
		`CHK(read_addr_out, 12'hF60)
		exec(16'h2210, 8'h80, 8'h80, 5'h00, 1'b0);
		`CHK(result_out, {1'b0, 1'b1, 12'h010, 8'h00})
		`CHK({flags_wr_out, status_out}, 6'h2D)
		exec(16'h0B5F, 8'hA3, 8'h00, 5'h1F, 1'b0);
		`CHK({result_out.wr_accum, result_out.wr_file, result_out.value}, 10'h203)
		`CHK(status_out, 5'h0B)
		exec(16'h165F, 8'h0F, 8'hF0, 5'h00, 1'b1);
		`CHK(result_out, {1'b0, 1'b1, 12'h15F, 8'h00})
		`CHK(read_addr_out, 12'h15F)
		`CHK(status_out, 5'h04)
		exec(16'h9F40, 8'h00, 8'hC7, 5'h1F, 1'b0);
		`CHK(result_out, {1'b0, 1'b1, 12'h340, 8'h47})
		`CHK({flags_wr_out, status_out}, 6'h1F)
		exec(16'hE280, 8'h00, 8'h00, 5'h01, 1'b0);
		`CHK({bt, tg}, {1'b1, 21'h000002})
		`CHK(cyc, 9)
		`CHK(flags_wr_out, 1'b0)
		exec(16'hE205, 8'h00, 8'h00, 5'h01, 1'b0);
		`CHK({bt, tg}, {1'b1, 21'h00010C})
		`CHK(cyc, 9)
		exec(16'hE27F, 8'h00, 8'h00, 5'h00, 1'b0);
		`CHK({bt, cyc}, {1'b0, 32'd5})
		summarize();
	end
endmodule

// ### hw/add_and_branch_bitclear_exec.sv
// Overview of operation
// RL1: Add accumulator, carry and file byte.
// RL2: Destination bit picks accumulator or file.
// RL3: Access bit picks access or pointed bank.
// RL4: Extended, access, low address uses indexing.
// RL5: AND immediate into accumulator.
// RL6: AND file with accumulator to destination.
// RL7: AND updates only negative and zero.
// RL8: Branch only when carry set, no flags.
// RL9: Target is counter plus two plus 2n.
// RL10: Taken branch adds one no-operation cycle.
// RL11: Clear one chosen bit, flags untouched.
// RL12: Add sets five flags; one cycle each. A taken branch here takes two cycles.
`timescale 1ns/1ps
module add_and_branch_bitclear_exec
	import exec_pkg::*;
(
	input  wire logic                  ref_clk_in,
	input  wire logic                  reset_in,
	input  wire logic                  insn_valid_in,
	input  wire logic [INSN_W-1:0]     insn_in,
	input  wire logic [DATA_W-1:0]     accum_in,
	input  wire logic [DATA_W-1:0]     file_data_in,
	input  wire logic [FLAG_W-1:0]     status_in,
	input  wire logic [PC_W-1:0]       program_counter_in,
	input  wire logic [BANK_W-1:0]     bank_pointer_register_in,
	input  wire logic [ADDR_W-1:0]     index_base_in,
	input  wire logic                  extended_in,
	output logic      [ADDR_W-1:0]     read_addr_out,
	output exec_pkg::result_t          result_out,
	output logic                       flags_wr_out,
	output logic      [FLAG_W-1:0]     status_out,
	output exec_pkg::branch_t          branch_out,
	output logic      [PHASE_W-1:0]    phase_out,
	output logic                       busy_out,
	output logic                       done_out
);
	import exec_pkg::*;

	typedef enum {ST_IDLE, ST_EXEC, ST_FLUSH} state_t;

	state_t             state_r, state_nxt;
	logic [PHASE_W-1:0] phase_r, phase_nxt;
	logic [INSN_W-1:0]  insn_r, insn_nxt;
	logic [ADDR_W-1:0]  addr_r, addr_nxt;
	result_t            result_r, result_nxt;
	logic               flags_wr_r, flags_wr_nxt;
	logic [FLAG_W-1:0]  status_r, status_nxt;
	branch_t            branch_r, branch_nxt;
	logic               done_r, done_nxt;

	logic [ADDR_W-1:0]  sel_addr;
	logic [3:0]         op_hi;
	logic [1:0]         op_sub;
	logic               dest_bit;
	logic [2:0]         bit_pos;
	logic [8:0]         sum;
	logic [4:0]         low_sum;
	logic [DATA_W-1:0]  res;
	logic [PC_W-1:0]    offset2;

	// One decode line per supported word; anything else finishes without writes.
	logic               is_add_carry;
	logic               is_and_imm;
	logic               is_and_file;
	logic               is_branch_c;
	logic               is_clear_bit;

	file_address_select u_addr (
		.file_in                  (insn_nxt[7:0]),
		.access_sel_in            (insn_nxt[8]),
		.extended_in              (extended_in),
		.bank_pointer_register_in (bank_pointer_register_in),
		.index_base_in            (index_base_in),
		.addr_out                 (sel_addr),
		.indexed_out              ()
	);

	always_comb begin
		state_nxt    = state_r;
		phase_nxt    = phase_r;
		insn_nxt     = insn_r;
		addr_nxt     = addr_r;
		result_nxt   = '0;
		flags_wr_nxt = 1'b0;
		status_nxt   = status_r;
		branch_nxt   = '0;
		done_nxt     = 1'b0;
		op_hi        = insn_r[15:12];
		op_sub       = insn_r[11:10];
		dest_bit     = insn_r[9];
		bit_pos      = insn_r[11:9];
		sum          = '0;
		low_sum      = '0;
		res          = '0;
		// The offset is doubled because every instruction word is two bytes.
		offset2      = {{(PC_W-9){insn_r[7]}}, insn_r[7:0], 1'b0};
		is_add_carry = (op_hi == OP_ADD_CARRY) && (op_sub == SUB_ADD_CARRY); // see RL1
		is_and_imm   = (insn_r[15:8] == OP_AND_IMM); // see RL5
		is_and_file  = (op_hi == OP_AND_FILE) && (op_sub == SUB_AND_FILE); // see RL6
		is_branch_c  = (insn_r[15:8] == OP_BRANCH_C); // see RL8
		is_clear_bit = (op_hi == OP_CLEAR_BIT); // see RL11
		unique case (state_r)
			ST_IDLE: begin
				if (insn_valid_in) begin
					insn_nxt  = insn_in;
					addr_nxt  = sel_addr;
					phase_nxt = '0;
					state_nxt = ST_EXEC;
				end
			end
			ST_EXEC: begin
				phase_nxt = phase_r + 2'h1; // see RL12
				// Flags are read at the last phase, so the core must hold them until then.
				if (phase_r == LAST_PHASE) begin
					status_nxt = status_in;
					done_nxt   = 1'b1;
					state_nxt  = ST_IDLE;
					if (is_add_carry) begin
						sum     = {1'b0, accum_in} + {1'b0, file_data_in}
						          + {8'h00, status_in[FLAG_C]}; // see RL1
						low_sum = {1'b0, accum_in[3:0]} + {1'b0, file_data_in[3:0]}
						          + {4'h0, status_in[FLAG_C]};
						res     = sum[7:0];
						result_nxt.wr_accum = !dest_bit; // see RL2
						result_nxt.wr_file  = dest_bit; // see RL2
						flags_wr_nxt = 1'b1;
						status_nxt[FLAG_C]  = sum[8]; // see RL12
						status_nxt[FLAG_DC] = low_sum[4]; // see RL12
						status_nxt[FLAG_Z]  = (res == 8'h00); // see RL12
						status_nxt[FLAG_N]  = res[7]; // see RL12
						status_nxt[FLAG_OV] = (accum_in[7] == file_data_in[7])
						                      && (res[7] != accum_in[7]); // see RL12
					end else if (is_and_imm) begin
						res = accum_in & insn_r[7:0]; // see RL5
						result_nxt.wr_accum = 1'b1; // see RL5
						flags_wr_nxt = 1'b1;
						status_nxt[FLAG_Z] = (res == 8'h00); // see RL7
						status_nxt[FLAG_N] = res[7]; // see RL7
					end else if (is_and_file) begin
						res = accum_in & file_data_in; // see RL6
						result_nxt.wr_accum = !dest_bit; // see RL2
						result_nxt.wr_file  = dest_bit; // see RL2
						flags_wr_nxt = 1'b1;
						status_nxt[FLAG_Z] = (res == 8'h00); // see RL7
						status_nxt[FLAG_N] = res[7]; // see RL7
					end else if (is_branch_c) begin
						if (status_in[FLAG_C]) begin // see RL8
							branch_nxt.taken  = 1'b1;
							branch_nxt.target = program_counter_in + PC_STEP + offset2; // see RL9
							done_nxt  = 1'b0;
							phase_nxt = '0;
							state_nxt = ST_FLUSH; // see RL10
						end
					end else if (is_clear_bit) begin
						res = file_data_in & ~(8'h01 << bit_pos); // see RL11
						result_nxt.wr_file = 1'b1; // see RL11
					end
					result_nxt.file_addr = addr_r;
					result_nxt.value     = res;
				end
			end
			// A taken branch spends a whole extra instruction cycle as a no-operation.
			ST_FLUSH: begin
				phase_nxt = phase_r + 2'h1; // see RL10
				if (phase_r == LAST_PHASE) begin
					done_nxt  = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
		endcase
		// Words outside this set write nothing; of them only a taken branch drives branch_out and takes an extra cycle.
		if (!(is_add_carry || is_and_imm || is_and_file || is_clear_bit)) begin
			result_nxt.wr_accum = 1'b0;
			result_nxt.wr_file  = 1'b0;
			flags_wr_nxt        = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state_r    <= ST_IDLE;
			phase_r    <= '0;
			insn_r     <= '0;
			addr_r     <= '0;
			result_r   <= '0;
			flags_wr_r <= 1'b0;
			status_r   <= '0;
			branch_r   <= '0;
			done_r     <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			phase_r    <= phase_nxt;
			insn_r     <= insn_nxt;
			addr_r     <= addr_nxt;
			result_r   <= result_nxt;
			flags_wr_r <= flags_wr_nxt;
			status_r   <= status_nxt;
			branch_r   <= branch_nxt;
			done_r     <= done_nxt;
		end
	end

	// Busy mirrors the state register, so a new word is refused until completion.
	logic busy_r;
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= (state_nxt != ST_IDLE);
		end
	end

	assign read_addr_out = addr_r;
	assign result_out    = result_r;
	assign flags_wr_out  = flags_wr_r;
	assign status_out    = status_r;
	assign branch_out    = branch_r;
	assign phase_out     = phase_r;
	assign busy_out      = busy_r;
	assign done_out      = done_r;
endmodule

// ### hw/exec_pkg.sv
package exec_pkg;

	localparam int DATA_W     = 8;
	localparam int INSN_W     = 16;
	localparam int PC_W       = 21;
	localparam int ADDR_W     = 12;
	localparam int BANK_W     = 4;
	localparam int PHASES     = 4;
	localparam int PHASE_W    = 2;

	localparam logic [3:0] OP_ADD_CARRY  = 4'h2;
	localparam logic [1:0] SUB_ADD_CARRY = 2'h0;
	localparam logic [7:0] OP_AND_IMM    = 8'h0B;
	localparam logic [3:0] OP_AND_FILE   = 4'h1;
	localparam logic [1:0] SUB_AND_FILE  = 2'h1;
	localparam logic [7:0] OP_BRANCH_C   = 8'hE2;
	localparam logic [3:0] OP_CLEAR_BIT  = 4'h9;

	localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
	localparam logic [7:0] ACCESS_SPLIT  = 8'h60;
	localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;
	localparam logic [1:0] LAST_PHASE    = 2'h3;

	localparam int FLAG_C  = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z  = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_N  = 4;
	localparam int FLAG_W  = 5;

	typedef struct packed {
		logic             wr_accum;
		logic             wr_file;
		logic [ADDR_W-1:0] file_addr;
		logic [DATA_W-1:0] value;
	} result_t;

	typedef struct packed {
		logic             taken;
		logic [PC_W-1:0]  target;
	} branch_t;

endpackage

// ### hw/file_address_select.sv
`timescale 1ns/1ps
module file_address_select
	import exec_pkg::*;
(
	input  wire logic [7:0]        file_in,
	input  wire logic              access_sel_in,
	input  wire logic              extended_in,
	input  wire logic [BANK_W-1:0] bank_pointer_register_in,
	input  wire logic [ADDR_W-1:0] index_base_in,
	output logic      [ADDR_W-1:0] addr_out,
	output logic                   indexed_out
);
	always_comb begin
		indexed_out = !access_sel_in && extended_in && (file_in <= INDEXED_LIMIT); // see RL4
		if (indexed_out) begin
			addr_out = index_base_in + {4'h0, file_in}; // see RL4
		end else if (access_sel_in) begin
			addr_out = {bank_pointer_register_in, file_in}; // see RL3
		end else if (file_in < ACCESS_SPLIT) begin
			addr_out = {4'h0, file_in}; // see RL3
		end else begin
			addr_out = {ACCESS_HI_BANK, file_in}; // see RL3
		end
	end
endmodule
